// >>> rtl/vref_pkg.sv
// Constants, field layout and gain encodings for the voltage reference control block.
// Assumes a single 200 MHz system clock and an 8-bit register port.
package vref_pkg;

  // Clock period and the times that are turned into cycle counts.
  localparam int CLK_PERIOD_NS = 5;
  localparam int BUF_SETTLE_NS = 30000;
  localparam int BUF_SETTLE_CYC = (BUF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_SETTLE_NS = 20000;
  localparam int REF_SETTLE_CYC = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register map.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h1;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

  // Control register fields.
  localparam int BIT_EN = 7;
  localparam int BIT_RDY = 6;
  localparam int BIT_TS_EN = 5;
  localparam int BIT_TS_RNG = 4;
  localparam int CMP_LSB = 2;
  localparam int CONV_LSB = 0;
  localparam int GAIN_W = 2;

  // Status register fields.
  localparam int STAT_CONV_BUF = 0;
  localparam int STAT_CMP_BUF = 1;
  localparam int STAT_DEMAND = 2;
  localparam int STAT_OSC_KEEP = 3;

  // Clock and brown-out settings that make other units need the reference.
  localparam logic [2:0] OSC_SEL_INTERNAL = 3'h4;
  localparam logic [2:0] FREQ_SEL_IDLE_HI = 3'h0;
  localparam logic [1:0] BOR_ALWAYS = 2'h3;
  localparam logic [1:0] BOR_NO_SLEEP = 2'h2;
  localparam logic [1:0] BOR_SOFTWARE = 2'h1;

  // Gain stage settings, shared by the converter and the comparator/DAC path.
  typedef enum logic [GAIN_W-1:0] {
    GAIN_OFF = 2'h0,
    GAIN_1X = 2'h1,
    GAIN_2X = 2'h2,
    GAIN_4X = 2'h3
  } gain_e;

  // A gain stage whose field is not off drives its buffer output.
  function automatic logic gain_active(input gain_e g);
    return g != GAIN_OFF;
  endfunction

endpackage

// >>> rtl/settle_if.sv
// Start and done pair between the control logic and one settle timer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface settle_if;
  logic run;
  logic done;
  modport ctrl (output run, input done);
  modport timer (input run, output done);
endinterface

// >>> rtl/settle_timer.sv
// Settle timer: done rises CYCLES edges after run rises and drops once run is low.
// Assumes run is a registered level from the same clock domain.
`timescale 1ns/1ps
module settle_timer
  #(parameter int CYCLES = 4)
  (input wire logic i_clk,
   input wire logic i_nrst,
   settle_if.timer sif);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  // Counting stops at the last value so a long run never wraps back to not ready.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      count <= '0;
      sif.done <= 1'b0;
    end
    else if (!sif.run)
    begin
      count <= '0;
      sif.done <= 1'b0;
    end
    else if (!sif.done)
    begin
      if (count == LAST)
        sif.done <= 1'b1;
      else
        count <= count + 1'b1;
    end
  end

  done_drop_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !sif.run |=> !sif.done) else $error("Settle done stayed high without run.");
  done_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    sif.run && sif.done |=> sif.done) else $error("Settle done lost while running.");

endmodule // settle_timer

// >>> rtl/reference_demand.sv
// Works out when other units need the fixed reference and the fast oscillator.
// Assumes all inputs are synchronous configuration levels from the same clock.
`timescale 1ns/1ps
module reference_demand
  import vref_pkg::*;
  #(parameter logic [1:0] SW_CLK_64M_SEL = 2'h1)
  (input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [2:0] i_osc_src_sel,
   input wire logic [3:0] i_internal_freq_sel,
   input wire logic i_sleep,
   input wire logic [1:0] i_brownout_mode,
   input wire logic i_brownout_fast_start,
   input wire logic i_regulator_power_mode,
   input wire logic i_std_variant,
   input wire logic [1:0] i_switch_ctrl_clock_sel,
   output logic o_demand,
   output logic o_osc_keep);

  logic osc_demand;
  logic bor_demand;
  logic ldo_demand;
  logic next_keep;
  logic next_demand;

  // Each source of demand is decoded on its own wire so the terms stay visible.
  assign osc_demand = (i_osc_src_sel == OSC_SEL_INTERNAL) &&
                      (i_internal_freq_sel[3:1] != FREQ_SEL_IDLE_HI) && !i_sleep;
  assign bor_demand = (i_brownout_mode == BOR_ALWAYS) ||
                      (((i_brownout_mode == BOR_NO_SLEEP) ||
                        (i_brownout_mode == BOR_SOFTWARE)) && i_brownout_fast_start);
  // In sleep the low-power regulator takes over, so it stops asking.
  assign ldo_demand = i_std_variant && i_regulator_power_mode && !i_sleep;
  assign next_keep = (i_switch_ctrl_clock_sel == SW_CLK_64M_SEL);
  assign next_demand = osc_demand || bor_demand || ldo_demand || next_keep;

  // Registered so that the top outputs come straight from flip-flops.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_demand <= 1'b0;
      o_osc_keep <= 1'b0;
    end
    else
    begin
      o_demand <= next_demand;
      o_osc_keep <= next_keep;
    end
  end

  osc_need_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_osc_src_sel == OSC_SEL_INTERNAL) && (i_internal_freq_sel[3:1] != FREQ_SEL_IDLE_HI)
    && !i_sleep |=> o_demand) else $error("Internal oscillator did not demand.");
  bor_need_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_brownout_mode == BOR_ALWAYS) || (i_brownout_mode != 2'h0 && i_brownout_fast_start)
    |=> o_demand) else $error("Brown-out setting did not demand.");
  ldo_need_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_std_variant && i_regulator_power_mode && !i_sleep |=> o_demand)
    else $error("Regulator did not demand.");
  osc_keep_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_switch_ctrl_clock_sel == SW_CLK_64M_SEL) |=> o_osc_keep && o_demand)
    else $error("Fast clock selection did not keep oscillator.");

endmodule // reference_demand

// >>> rtl/voltage_reference_control.sv
// Control and status register for the fixed voltage reference and thermal sense.
// Assumes a one-cycle strobe register port and synchronous configuration inputs.
//
// Overview of operation
// - Enable bit seven switches reference on/off.
// - Ready sets only after reference settles.
// - Ready reads zero when off; read-only.
// - Ready reset value depends on device variant; code resets it to zero, standard variant sets it two edges after reset.
// - Standard-voltage variant always reads ready as one.
// - Bits 3-2 set comparator/DAC gain or off.
// - Bits 1-0 set converter gain or off.
// - Both gain stages configured independently.
// - Bit five enables thermal sense.
// - Bit four selects thermal sense high range.
// - Writable fields reset to zero on every reset.
// - Internal fast oscillator running awake needs reference.
// - Brown-out modes with fast start need reference.
// - Regulator in power mode awake needs reference, standard variant only.
// - Fast switch-controller clock keeps oscillator in sleep.
`timescale 1ns/1ps
module voltage_reference_control
  import vref_pkg::*;
  #(parameter int REF_SETTLE_CYCLES = REF_SETTLE_CYC,
    parameter int BUF_SETTLE_CYCLES = BUF_SETTLE_CYC,
    parameter logic [1:0] SW_CLK_64M_SEL = 2'h1)
  (input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_std_variant,
   input wire logic [2:0] i_osc_src_sel,
   input wire logic [3:0] i_internal_freq_sel,
   input wire logic i_sleep,
   input wire logic [1:0] i_brownout_mode,
   input wire logic i_brownout_fast_start,
   input wire logic i_regulator_power_mode,
   input wire logic [1:0] i_switch_ctrl_clock_sel,
   output logic [DATA_W-1:0] o_rdata,
   output logic o_reference_enable,
   output logic o_reference_ready,
   output logic o_ref_on,
   output logic o_thermal_sense_enable,
   output logic o_thermal_sense_range,
   output gain_e o_cmp_dac_gain_sel,
   output gain_e o_converter_gain_sel,
   output logic o_conv_buf_ready,
   output logic o_cmp_buf_ready,
   output logic o_ref_demand,
   output logic o_osc_keep_awake);

  logic ctrl_wr;
  logic ctrl_rd;
  logic stat_rd;
  logic variant_q;
  logic [DATA_W-1:0] ctrl_image;
  logic [DATA_W-1:0] stat_image;
  logic [DATA_W-1:0] next_rdata;
  logic next_ready;

  settle_if ref_sif ();
  settle_if conv_sif ();
  settle_if cmp_sif ();

  // Address decode; every access hits the register port in one cycle, no waits.
  assign ctrl_wr = i_wr && (i_addr == CTRL_OFS);
  assign ctrl_rd = i_rd && (i_addr == CTRL_OFS);
  assign stat_rd = i_rd && (i_addr == STAT_OFS);

  // Control fields take the write data; the ready bit position is not stored.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_reference_enable <= CTRL_RESET[BIT_EN];
      o_thermal_sense_enable <= CTRL_RESET[BIT_TS_EN];
      o_thermal_sense_range <= CTRL_RESET[BIT_TS_RNG];
      o_cmp_dac_gain_sel <= gain_e'(CTRL_RESET[CMP_LSB +: GAIN_W]);
      o_converter_gain_sel <= gain_e'(CTRL_RESET[CONV_LSB +: GAIN_W]);
    end
    else if (ctrl_wr)
    begin
      o_reference_enable <= i_wdata[BIT_EN];
      o_thermal_sense_enable <= i_wdata[BIT_TS_EN];
      o_thermal_sense_range <= i_wdata[BIT_TS_RNG];
      o_cmp_dac_gain_sel <= gain_e'(i_wdata[CMP_LSB +: GAIN_W]);
      o_converter_gain_sel <= gain_e'(i_wdata[CONV_LSB +: GAIN_W]);
    end
  end

  // The variant strap is caught by the clock after reset, never by the reset itself.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      variant_q <= 1'b0;
    else
      variant_q <= i_std_variant;
  end

  // Reference settle timer runs while the enable bit is set.
  assign ref_sif.run = o_reference_enable;

  settle_timer #(.CYCLES(REF_SETTLE_CYCLES)) u_ref_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .sif(ref_sif)
  );

  // Each gain stage gets its own buffer timer, so one path never delays the other.
  assign conv_sif.run = gain_active(o_converter_gain_sel);
  assign cmp_sif.run = gain_active(o_cmp_dac_gain_sel);

  settle_timer #(.CYCLES(BUF_SETTLE_CYCLES)) u_conv_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .sif(conv_sif)
  );

  settle_timer #(.CYCLES(BUF_SETTLE_CYCLES)) u_cmp_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .sif(cmp_sif)
  );

  // Buffer ready is only a hint; software still owns the buffer wait.
  assign o_conv_buf_ready = conv_sif.done;
  assign o_cmp_buf_ready = cmp_sif.done;

  reference_demand #(.SW_CLK_64M_SEL(SW_CLK_64M_SEL)) u_demand (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_osc_src_sel(i_osc_src_sel),
    .i_internal_freq_sel(i_internal_freq_sel),
    .i_sleep(i_sleep),
    .i_brownout_mode(i_brownout_mode),
    .i_brownout_fast_start(i_brownout_fast_start),
    .i_regulator_power_mode(i_regulator_power_mode),
    .i_std_variant(i_std_variant),
    .i_switch_ctrl_clock_sel(i_switch_ctrl_clock_sel),
    .o_demand(o_ref_demand),
    .o_osc_keep(o_osc_keep_awake)
  );

  // Ready follows the settle timer, or is forced high on the standard variant.
  // It depends on the stored enable, so it falls one edge after the enable bit clears.
  assign next_ready = variant_q || (o_reference_enable && ref_sif.done);

  // The reference runs for software or for any unit that needs it.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_reference_ready <= 1'b0;
      o_ref_on <= 1'b0;
    end
    else
    begin
      o_reference_ready <= next_ready;
      o_ref_on <= o_reference_enable || o_ref_demand;
    end
  end

  // Read images; unused status bits and unmapped addresses read as zero.
  assign ctrl_image = {o_reference_enable, o_reference_ready, o_thermal_sense_enable,
                       o_thermal_sense_range, o_cmp_dac_gain_sel, o_converter_gain_sel};
  always_comb
  begin
    stat_image = READ_IDLE;
    stat_image[STAT_CONV_BUF] = o_conv_buf_ready;
    stat_image[STAT_CMP_BUF] = o_cmp_buf_ready;
    stat_image[STAT_DEMAND] = o_ref_demand;
    stat_image[STAT_OSC_KEEP] = o_osc_keep_awake;
  end
  assign next_rdata = ctrl_rd ? ctrl_image : (stat_rd ? stat_image : READ_IDLE);

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_rdata <= READ_IDLE;
    else
      o_rdata <= next_rdata;
  end

  // Helper logic for the checks below: enable age and the first cycle after reset.
  localparam int AGE_W = $clog2(REF_SETTLE_CYCLES + 3);
  localparam logic [AGE_W-1:0] AGE_FULL = AGE_W'(REF_SETTLE_CYCLES + 1);

  logic [AGE_W-1:0] en_age;
  logic after_rst;

  // Ready may only rise once the enable has stood for the full settle time.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      en_age <= '0;
    else if (!o_reference_enable)
      en_age <= '0;
    else if (en_age != AGE_FULL)
      en_age <= en_age + 1'b1;
  end

  // Marks the first edge after reset, where the cleared fields are checked.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      after_rst <= 1'b1;
    else
      after_rst <= 1'b0;
  end

  // Converter buffer age, counted apart from its timer so the end point is checked.
  localparam int BUF_AGE_W = $clog2(BUF_SETTLE_CYCLES + 2);
  localparam logic [BUF_AGE_W-1:0] BUF_AGE_FULL = BUF_AGE_W'(BUF_SETTLE_CYCLES);

  logic [BUF_AGE_W-1:0] conv_age;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      conv_age <= '0;
    else if (!gain_active(o_converter_gain_sel))
      conv_age <= '0;
    else if (conv_age != BUF_AGE_FULL)
      conv_age <= conv_age + 1'b1;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // Field, ready and buffer checks; the expected values come from the write data, past field values and the age counters.
  enable_write_a: assert property (
    ctrl_wr |=> o_reference_enable == $past(i_wdata[BIT_EN]))
    else $error("Enable bit did not take the written value.");
  ready_settle_a: assert property (
    o_reference_enable && !variant_q && en_age == AGE_FULL |-> o_reference_ready)
    else $error("Ready missing after the settle time.");
  ready_early_a: assert property (
    o_reference_ready && o_reference_enable && !variant_q |-> en_age == AGE_FULL)
    else $error("Ready set before the settle time.");
  ready_off_a: assert property (
    !o_reference_enable && !variant_q |=> !o_reference_ready)
    else $error("Ready high while the reference is off.");
  ready_read_a: assert property (
    ctrl_rd |=> o_rdata == {$past(o_reference_enable), $past(o_reference_ready),
                            $past(o_thermal_sense_enable), $past(o_thermal_sense_range),
                            $past(o_cmp_dac_gain_sel), $past(o_converter_gain_sel)})
    else $error("Control read returned wrong data.");
  read_idle_a: assert property (
    !i_rd |=> o_rdata == READ_IDLE)
    else $error("Read data present without a read strobe.");
  std_ready_a: assert property (
    variant_q |=> o_reference_ready)
    else $error("Standard variant ready not one.");
  reset_clear_a: assert property (
    after_rst |-> !o_reference_enable && !o_thermal_sense_enable && !o_thermal_sense_range
                  && o_cmp_dac_gain_sel == GAIN_OFF && o_converter_gain_sel == GAIN_OFF)
    else $error("Control fields not cleared by reset.");
  reset_ready_a: assert property (
    after_rst ##1 variant_q |=> o_reference_ready)
    else $error("Ready after reset ignores the variant.");
  gain_write_a: assert property (
    ctrl_wr |=> o_cmp_dac_gain_sel == $past(i_wdata[CMP_LSB +: GAIN_W])
                && o_converter_gain_sel == $past(i_wdata[CONV_LSB +: GAIN_W]))
    else $error("Gain fields not written independently.");
  cmp_gain_a: assert property (
    ctrl_wr && i_wdata[CMP_LSB +: GAIN_W] == GAIN_OFF |=> ##1 !o_cmp_buf_ready)
    else $error("Comparator buffer ready while its gain is off.");
  conv_gain_a: assert property (
    ctrl_wr && i_wdata[CONV_LSB +: GAIN_W] == GAIN_OFF |=> ##1 !o_conv_buf_ready)
    else $error("Converter buffer ready while its gain is off.");
  thermal_a: assert property (
    ctrl_wr |=> o_thermal_sense_enable == $past(i_wdata[BIT_TS_EN])
                && o_thermal_sense_range == $past(i_wdata[BIT_TS_RNG]))
    else $error("Thermal sense fields not written.");
  ref_on_a: assert property (
    o_reference_enable || o_ref_demand |=> o_ref_on)
    else $error("Reference not running while needed.");
  ref_off_a: assert property (
    !o_reference_enable && !o_ref_demand |=> !o_ref_on)
    else $error("Reference still running while unused.");
  ready_readonly_a: assert property (
    ctrl_wr && i_wdata[BIT_RDY] && !ref_sif.done && !variant_q |=> !o_reference_ready)
    else $error("Writing the ready bit set the ready flag.");
  cmp_off_a: assert property (
    o_cmp_dac_gain_sel == GAIN_OFF |=> !o_cmp_buf_ready)
    else $error("Comparator buffer ready with its output off.");
  conv_off_a: assert property (
    o_converter_gain_sel == GAIN_OFF |=> !o_conv_buf_ready)
    else $error("Converter buffer ready with its output off.");
  conv_buf_time_a: assert property (
    o_conv_buf_ready == (conv_age == BUF_AGE_FULL))
    else $error("Converter buffer ready at the wrong time.");

  // Main scenarios the bench is expected to reach.
  enable_ready_c: cover property (!variant_q && o_reference_enable && $rose(o_reference_ready));
  std_read_c: cover property (variant_q && ctrl_rd ##1 o_rdata[BIT_RDY]);
  cmp_buf_c: cover property ($rose(o_cmp_buf_ready));
  demand_c: cover property ($rose(o_ref_demand) && !o_reference_enable);
  osc_keep_c: cover property ($rose(o_osc_keep_awake));

endmodule // voltage_reference_control

// >>> testbench/voltage_reference_control_tb_top.sv
// Self-checking bench for the voltage reference control block.
// Assumes the block's strobe register port and short settle counts set below.
`timescale 1ns/1ps
module voltage_reference_control_tb_top
  import vref_pkg::*;
  ;
  // Short settle counts keep the run brief; ready and buffer differ on purpose.
  localparam int REF_N = 4;
  localparam int BUF_N = 6;

  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_std_variant = 1'b0;
  logic [2:0] i_osc_src_sel = 3'h0;
  logic [3:0] i_internal_freq_sel = 4'h0;
  logic i_sleep = 1'b0;
  logic [1:0] i_brownout_mode = 2'h0;
  logic i_brownout_fast_start = 1'b0;
  logic i_regulator_power_mode = 1'b0;
  logic [1:0] i_switch_ctrl_clock_sel = 2'h0;
  logic [DATA_W-1:0] o_rdata;
  logic o_reference_enable;
  logic o_reference_ready;
  logic o_ref_on;
  logic o_thermal_sense_enable;
  logic o_thermal_sense_range;
  gain_e o_cmp_dac_gain_sel;
  gain_e o_converter_gain_sel;
  logic o_conv_buf_ready;
  logic o_cmp_buf_ready;
  logic o_ref_demand;
  logic o_osc_keep_awake;
  int fail_count = 0;
  int checked = 0;

  voltage_reference_control #(.REF_SETTLE_CYCLES(REF_N), .BUF_SETTLE_CYCLES(BUF_N)) u_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_std_variant(i_std_variant), .i_osc_src_sel(i_osc_src_sel),
    .i_internal_freq_sel(i_internal_freq_sel), .i_sleep(i_sleep),
    .i_brownout_mode(i_brownout_mode), .i_brownout_fast_start(i_brownout_fast_start),
    .i_regulator_power_mode(i_regulator_power_mode),
    .i_switch_ctrl_clock_sel(i_switch_ctrl_clock_sel), .o_rdata(o_rdata),
    .o_reference_enable(o_reference_enable), .o_reference_ready(o_reference_ready),
    .o_ref_on(o_ref_on), .o_thermal_sense_enable(o_thermal_sense_enable),
    .o_thermal_sense_range(o_thermal_sense_range), .o_cmp_dac_gain_sel(o_cmp_dac_gain_sel),
    .o_converter_gain_sel(o_converter_gain_sel), .o_conv_buf_ready(o_conv_buf_ready),
    .o_cmp_buf_ready(o_cmp_buf_ready), .o_ref_demand(o_ref_demand),
    .o_osc_keep_awake(o_osc_keep_awake));

  // The 200 MHz system clock.
  initial
  begin
    forever #2.5 i_clk = ~i_clk;
  end

  // Prints the verdict and ends the run; reached from the main flow or the watchdog.
  task automatic conclude();
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Compares one flag; case inequality lets an unknown count as a mismatch.
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares one byte.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds reset low for three edges, changing it only right after an edge.
  task automatic do_reset();
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
  endtask

  // One-cycle write; returns just after the edge that takes it.
  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  // One-cycle read; the data are taken in the single cycle after the strobe.
  task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk8(o_rdata, exp);
  endtask

  // Applies one set of configuration levels and checks the demand outputs.
  task automatic cfg(input logic [2:0] osc, input logic [3:0] frq, input logic slp,
                     input logic [1:0] bor, input logic fs, input logic pm, input logic std,
                     input logic [1:0] sw, input logic exp_d, input logic exp_k);
    @(posedge i_clk);
    i_osc_src_sel <= osc;
    i_internal_freq_sel <= frq;
    i_sleep <= slp;
    i_brownout_mode <= bor;
    i_brownout_fast_start <= fs;
    i_regulator_power_mode <= pm;
    i_std_variant <= std;
    i_switch_ctrl_clock_sel <= sw;
    repeat (2) @(posedge i_clk);
    #1;
    chk1(o_ref_demand, exp_d);
    chk1(o_osc_keep_awake, exp_k);
    chk1(o_ref_on, exp_d);
    read_chk(STAT_OFS, {4'h0, exp_k, exp_d, 2'b00});
  endtask

  // Cuts a hang short; no scenario comes near this many cycles.
  initial
  begin
    repeat (100000) @(posedge i_clk);
    fail_count++;
    conclude();
  end

  // Main sequence of register scenarios.
  initial
  begin
    do_reset();
    read_chk(CTRL_OFS, 8'h00);
    read_chk(STAT_OFS, 8'h00);
    read_chk(4'hF, 8'h00);
    // Bit 6 written high must not set ready; both buffers start settling too.
    bus_write(CTRL_OFS, 8'hC5);
    chk1(o_reference_enable, 1'b1);
    for (int i = 1; i <= 8; i++)
    begin
      @(posedge i_clk);
      #1;
      chk1(o_reference_ready, i >= REF_N + 1);
      chk1(o_conv_buf_ready, i >= BUF_N);
      chk1(o_cmp_buf_ready, i >= BUF_N);
      chk1(o_ref_on, 1'b1);
    end
    read_chk(CTRL_OFS, 8'hC5);
    read_chk(STAT_OFS, 8'h03);
    // Writes to the status place or an unmapped place leave control alone.
    bus_write(STAT_OFS, 8'h00);
    bus_write(4'hF, 8'h00);
    read_chk(CTRL_OFS, 8'hC5);
    bus_write(CTRL_OFS, 8'h05);
    chk1(o_reference_enable, 1'b0);
    @(posedge i_clk);
    #1;
    chk1(o_reference_ready, 1'b0);
    chk1(o_ref_on, 1'b0);
    read_chk(CTRL_OFS, 8'h05);
    // Each gain code on one path against a different code on the other.
    for (int g = 0; g < 4; g++)
    begin
      bus_write(CTRL_OFS, {4'h0, 2'(g), 2'(3 - g)});
      chk8({6'h00, o_cmp_dac_gain_sel}, 8'(g));
      chk8({6'h00, o_converter_gain_sel}, 8'(3 - g));
      read_chk(CTRL_OFS, {4'h0, 2'(g), 2'(3 - g)});
    end
    bus_write(CTRL_OFS, 8'h30);
    chk1(o_thermal_sense_enable, 1'b1);
    chk1(o_thermal_sense_range, 1'b1);
    bus_write(CTRL_OFS, 8'h10);
    chk1(o_thermal_sense_enable, 1'b0);
    chk1(o_thermal_sense_range, 1'b1);
    bus_write(CTRL_OFS, 8'h20);
    chk1(o_thermal_sense_enable, 1'b1);
    chk1(o_thermal_sense_range, 1'b0);
    bus_write(CTRL_OFS, 8'h00);
    // Conditions under which other units need the reference.
    cfg(3'h4, 4'h2, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
    cfg(3'h4, 4'h1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    cfg(3'h4, 4'h2, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    cfg(3'h0, 4'h2, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    cfg(3'h0, 4'h0, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    cfg(3'h0, 4'h2, 1'b0, 2'h3, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
    cfg(3'h0, 4'h0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    cfg(3'h0, 4'h0, 1'b0, 2'h2, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
    cfg(3'h0, 4'h0, 1'b0, 2'h1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
    cfg(3'h0, 4'h0, 1'b0, 2'h1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    cfg(3'h0, 4'h0, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0);
    cfg(3'h0, 4'h0, 1'b0, 2'h0, 1'b0, 1'b1, 1'b1, 2'h0, 1'b1, 1'b0);
    cfg(3'h0, 4'h0, 1'b1, 2'h0, 1'b0, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0);
    cfg(3'h0, 4'h0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 2'h1, 1'b1, 1'b1);
    cfg(3'h0, 4'h0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0);
    // Standard variant: ready reads one with the enable clear, after a fresh reset.
    // The fields are set first so that the reset has something to clear.
    bus_write(CTRL_OFS, 8'hBF);
    @(posedge i_clk);
    i_std_variant <= 1'b1;
    do_reset();
    repeat (2) @(posedge i_clk);
    #1;
    chk1(o_reference_ready, 1'b1);
    chk1(o_reference_enable, 1'b0);
    read_chk(CTRL_OFS, 8'h40);
    conclude();
  end
endmodule // voltage_reference_control_tb_top
